// file: rtl/cde_edge.sv
// Purpose: glitch filter and edge/condition detector for the two bus wires
// Assumes: pins already synchronous to sys_clk
// Notes:   outputs are one-cycle pulses plus filtered levels
module cde_edge
  import cde_pkg::*;
#(
  parameter int DEPTH = CDE_FILT_CYC
) (
  // clock and reset
  input  wire logic      sys_clk,
  input  wire logic      sys_rst,
  // raw pins
  input  cde_pins_t      pins,
  // filtered results
  output cde_pins_t      lvl,
  output logic           scl_rise,
  output logic           scl_fall,
  output logic           start_det,
  output logic           stop_det
);
  // history needs two samples or more to agree on a level
  if (DEPTH < 2 || DEPTH > 8) begin : g_bad_depth
    $error("cde_edge: DEPTH out of range");
  end

  logic [DEPTH-1:0] scl_sh_r;  // scl history
  logic [DEPTH-1:0] sda_sh_r;  // sda history

  // ==========================================================
  // shift history, change level only when history agrees
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_sh_r <= '1;
      sda_sh_r <= '1;
      lvl      <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      scl_sh_r <= {scl_sh_r[DEPTH-2:0], pins.scl};
      sda_sh_r <= {sda_sh_r[DEPTH-2:0], pins.sda};
      if (&scl_sh_r) lvl.scl <= 1'b1;
      else if (~|scl_sh_r) lvl.scl <= 1'b0;
      if (&sda_sh_r) lvl.sda <= 1'b1;
      else if (~|sda_sh_r) lvl.sda <= 1'b0;
    end
  end

  cde_pins_t prev_r;  // level one cycle earlier

  // ==========================================================
  // edge and condition pulses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_r    <= '{scl: 1'b1, sda: 1'b1};
      scl_rise  <= 1'b0;
      scl_fall  <= 1'b0;
      start_det <= 1'b0;
      stop_det  <= 1'b0;
    end else begin
      prev_r    <= lvl;
      scl_rise  <= lvl.scl & ~prev_r.scl;
      scl_fall  <= ~lvl.scl & prev_r.scl;
      // sda moving while scl high marks start/stop
      start_det <= lvl.scl & prev_r.scl & prev_r.sda & ~lvl.sda;
      stop_det  <= lvl.scl & prev_r.scl & ~prev_r.sda & lvl.sda;
    end
  end
endmodule : cde_edge

// file: rtl/cde_pkg.sv
// Purpose: shared constants and types for the card data store
// Assumes: one 250 MHz clock, bus pins sampled synchronously
// Notes:   offsets, counts and reset values live here only
package cde_pkg;
  // ==========================================================
  // bus addressing
  localparam logic [6:0] CDE_ADDR_ABSENT  = 7'h56;  // card-presence low
  localparam logic [6:0] CDE_ADDR_PRESENT = 7'h57;  // card-presence high
  // ==========================================================
  // storage geometry
  localparam int         CDE_BYTES        = 64;     // usable bytes
  localparam int         CDE_PAGE_BYTES   = 32;     // page size
  localparam logic [15:0] CDE_TOP_ADDR    = 16'h003f; // last valid byte
  localparam logic [7:0] CDE_BLANK        = 8'hff;  // out-of-range read value
  localparam logic [7:0] CDE_MEM_RESET    = 8'hff;  // erased contents
  localparam logic [15:0] CDE_PTR_RESET   = 16'h0000;
  // ==========================================================
  // timing
  localparam int         CDE_CLK_MHZ      = 250;
  localparam int         CDE_TWR_US       = 5;      // internal write cycle
  localparam int         CDE_TWR_CYC      = CDE_TWR_US * CDE_CLK_MHZ;
  localparam int         CDE_FILT_CYC     = 2;      // pin filter depth

  // sampled bus pins
  typedef struct packed {
    logic scl;
    logic sda;
  } cde_pins_t;
endpackage : cde_pkg

// file: rtl/cde_store.sv
// Purpose: two-wire bus target holding 64 bytes in two 32-byte pages
// Assumes: master drives scl, pins synchronous to sys_clk
// Notes:   sys_rst is the chip reset, not the slot reset
// Behaviour
// - presence level picks one of two addresses
// - storage is two readable writable 32-byte pages
// - slot reset never blocks the store
// - 64 bytes from address zero upward
// - reads above top return all ones
// - writes above top dropped, still acknowledged
// - write pointer wraps inside its page
// - sequential reads any start, any length
module cde_store
  import cde_pkg::*;
#(
  parameter int BYTES    = CDE_BYTES,
  parameter int PAGE     = CDE_PAGE_BYTES,
  parameter int TWR_CYC  = CDE_TWR_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // card side
  input  wire logic card_present,
  input  wire logic slot_enable_low,
  // bus pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // status
  output logic      busy,
  output logic      if_enable
);
  // refuse geometries that the index slicing cannot serve
  if (BYTES != 2 * PAGE) begin : g_bad_pages
    $error("cde_store: need exactly two pages");
  end
  // page must be a power of two for the in-page wrap
  if (PAGE < 2 || PAGE > 128 || (PAGE & (PAGE - 1)) != 0) begin : g_bad_page
    $error("cde_store: page size unsupported");
  end
  if (TWR_CYC < 1) begin : g_bad_twr
    $error("cde_store: write time too small");
  end

  localparam int AW = $clog2(BYTES);  // stored index width
  localparam int PW = $clog2(PAGE);   // in-page width

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_AHI, ST_AHI_ACK, ST_ALO, ST_ALO_ACK,
    ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_SKIP
  } cde_state_t;

  // ==========================================================
  // helpers
  function automatic logic in_range(input logic [15:0] a);
    // top follows the size parameter, so smaller stores never alias
    return a <= 16'(BYTES - 1);
  endfunction : in_range

  function automatic logic [15:0] page_wrap(input logic [15:0] a);
    // keep page bits, step within page
    logic [15:0] r;
    r = a;
    r[PW-1:0] = a[PW-1:0] + 1'b1;
    return r;
  endfunction : page_wrap

  // ==========================================================
  // pin conditioning
  cde_pins_t pins_in;    // raw pins as one carrier
  cde_pins_t lvl;
  assign pins_in = '{scl: scl_i, sda: sda_i};
  logic      scl_rise;
  logic      scl_fall;
  logic      start_det;
  logic      stop_det;

  cde_edge u_edge (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .pins      (pins_in),
    .lvl       (lvl),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  cde_state_t  st_r;         // bus state
  logic [7:0]  sh_r;         // shift register
  logic [3:0]  bit_r;        // bit count in byte
  logic [15:0] ptr_r;        // memory pointer
  logic        rd_r;         // read direction
  logic        wpend_r;      // write data taken since start
  logic [7:0]  mem_r [BYTES];  // storage flip-flops
  logic [$clog2(TWR_CYC+1)-1:0] twr_r;  // write cycle countdown
  logic        ack_r;        // pull sda low
  logic [6:0]  my_addr;      // selected target address

  // presence selects target address
  assign my_addr = card_present ? CDE_ADDR_PRESENT : CDE_ADDR_ABSENT;

  // ==========================================================
  // bus state machine; slot reset is not an input here
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r    <= ST_IDLE;
      sh_r    <= 8'h00;
      bit_r   <= 4'h0;
      ptr_r   <= CDE_PTR_RESET;
      rd_r    <= 1'b0;
      wpend_r <= 1'b0;
      ack_r   <= 1'b0;
    end else if (start_det) begin
      st_r  <= ST_DEV;
      bit_r <= 4'h0;
      ack_r <= 1'b0;
      wpend_r <= 1'b0;
    end else if (stop_det) begin
      st_r  <= ST_IDLE;
      ack_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: ;  // wait for start
        ST_DEV, ST_AHI, ST_ALO, ST_WDATA: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], lvl.sda};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            bit_r <= 4'h0;
            case (st_r)
              ST_DEV: begin
                // match and not busy gives ack
                if (sh_r[7:1] == my_addr && twr_r == '0) begin
                  ack_r <= 1'b1;
                  rd_r  <= sh_r[0];
                  st_r  <= ST_DEV_ACK;
                end else begin
                  st_r <= ST_SKIP;
                end
              end
              ST_AHI: begin
                // high byte kept whole for range decode
                ptr_r[15:8] <= sh_r;
                ack_r       <= 1'b1;
                st_r        <= ST_AHI_ACK;
              end
              ST_ALO: begin
                ptr_r[7:0] <= sh_r;
                ack_r      <= 1'b1;
                st_r       <= ST_ALO_ACK;
              end
              default: begin
                // data byte; out of range dropped silently
                ack_r   <= 1'b1;
                wpend_r <= 1'b1;
                st_r    <= ST_WACK;
              end
            endcase
          end
        end
        ST_DEV_ACK, ST_AHI_ACK, ST_ALO_ACK, ST_WACK: begin
          if (scl_fall) begin
            ack_r <= 1'b0;
            case (st_r)
              ST_DEV_ACK: st_r <= rd_r ? ST_RDATA : ST_AHI;
              ST_AHI_ACK: st_r <= ST_ALO;
              ST_ALO_ACK: st_r <= ST_WDATA;
              default: begin
                // step within page only
                ptr_r <= page_wrap(ptr_r);
                st_r  <= ST_WDATA;
              end
            endcase
          end
        end
        ST_RDATA: begin
          // first bit was loaded on entry; shift on each fall
          if (scl_fall) begin
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h7) st_r <= ST_RACK;
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            // master nack ends the read, ack continues
            st_r  <= lvl.sda ? ST_SKIP : ST_RACK;
            ptr_r <= ptr_r + 16'h0001;
          end else if (scl_fall) begin
            bit_r <= 4'h0;
            st_r  <= ST_RDATA;
          end
        end
        ST_SKIP: ;  // ignore until start or stop
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // read data byte, all ones above the top
  logic [7:0] rd_byte;
  assign rd_byte = in_range(ptr_r) ? mem_r[ptr_r[AW-1:0]] : CDE_BLANK;

  // ==========================================================
  // sda drive: ack low, or read data bits msb first
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      if (st_r == ST_RDATA && !start_det && !stop_det) begin
        // open drain: enable only for a zero bit
        sda_oe <= ~rd_byte[3'd7 - bit_r[2:0]];
      end else begin
        sda_oe <= ack_r;
      end
    end
  end

  // ==========================================================
  // storage writes: commit on each acked in-range data byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < BYTES; i++) mem_r[i] <= CDE_MEM_RESET;
    end else if (st_r == ST_WDATA && scl_fall && bit_r == 4'h8 && !start_det && !stop_det) begin
      if (in_range(ptr_r)) mem_r[ptr_r[AW-1:0]] <= sh_r;
    end
  end

  // ==========================================================
  // write cycle timer starts at stop after written data
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      twr_r <= '0;
    end else if (stop_det && wpend_r && !rd_r) begin
      twr_r <= ($clog2(TWR_CYC+1))'(TWR_CYC);
    end else if (twr_r != '0) begin
      twr_r <= twr_r - 1'b1;
    end
  end

  // ==========================================================
  // status outputs; if_enable follows slot enable, other paths ignore it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy      <= 1'b0;
      if_enable <= 1'b0;
    end else begin
      busy      <= (twr_r != '0);
      if_enable <= ~slot_enable_low;
    end
  end
endmodule : cde_store

// file: sim/cde_host.sv
// Purpose: behavioural host controller, master of the two-wire bus
// Assumes: scl driven by this master alone, sda has a pull-up
// Notes:   pins move on falling sys_clk edges, 12-cycle scl phases
module cde_host (
  // clock
  input  wire logic sys_clk,
  // bus
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // fixed spacing, well above the filter depth of the target
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  // one bit: sda set mid scl-low, sampled mid scl-high
  task automatic bit_xfer(input logic b, output logic s);
    wt(6);
    sda_low = ~b;
    wt(6);
    scl = 1'b1;
    wt(6);
    s = sda_in;
    wt(6);
    scl = 1'b0;
  endtask : bit_xfer
  // start or repeated start
  task automatic bus_start();
    // release sda mid scl-low so a repeated start keeps a full low phase
    wt(6);
    sda_low = 1'b0;
    wt(6);
    scl = 1'b1;
    wt(12);
    sda_low = 1'b1;
    wt(12);
    scl = 1'b0;
  endtask : bus_start
  task automatic bus_stop();
    wt(6);
    sda_low = 1'b1;
    wt(6);
    scl = 1'b1;
    wt(12);
    sda_low = 1'b0;
    wt(12);
  endtask : bus_stop
  // byte out msb first, then answer bit
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask : put_byte
  // byte in; last byte gets no acknowledge
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(last, s);
  endtask : get_byte
endmodule : cde_host

// file: sim/cde_store_asserts.sv
// Purpose: port-level checks for the card data store
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every cde_store instance
module cde_store_asserts
  import cde_pkg::*;
#(
  parameter int BYTES   = CDE_BYTES,
  parameter int PAGE    = CDE_PAGE_BYTES,
  parameter int TWR_CYC = CDE_TWR_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // card side
  input wire logic card_present,
  input wire logic slot_enable_low,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // status
  input wire logic busy,
  input wire logic if_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // slack for filter and stop detection on top of the write cycle
  localparam int TWR_MAX = TWR_CYC + 16;
  // cycles spent busy; a counter, since the write cycle outgrows a delay range
  int busy_cnt_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !busy) busy_cnt_r <= 0;
    else busy_cnt_r <= busy_cnt_r + 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // bus pin behaviour
  a_sda_low_only: assert property (sda_o == 1'b0) else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i) else $error("sda moved with scl high");
  a_no_ack_busy: assert property (busy |-> !sda_oe) else $error("answer during write cycle");
  // ==========================================================
  // write cycle and status
  a_busy_at_stop: assert property ($rose(busy) |-> scl_i && sda_i) else $error("busy not after stop");
  a_busy_holds: assert property ($rose(busy) |-> busy [*8]) else $error("write cycle too short");
  a_busy_ends: assert property (busy |-> busy_cnt_r < TWR_MAX) else $error("write cycle hangs");
  a_busy_length: assert property ($fell(busy) |-> busy_cnt_r == TWR_CYC) else $error("write cycle length wrong");
  a_slot_follow: assert property (!$past(sys_rst) |-> if_enable == !$past(slot_enable_low))
    else $error("if_enable wrong");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !sda_oe && !busy && !if_enable)
    else $error("outputs active after reset");
endmodule : cde_store_asserts

bind cde_store cde_store_asserts #(.BYTES(BYTES), .PAGE(PAGE), .TWR_CYC(TWR_CYC)) cde_store_asserts_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .card_present(card_present), .slot_enable_low(slot_enable_low),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy), .if_enable(if_enable));

// file: sim/cde_store_tb.sv
// Purpose: self-checking bench for the card data store
// Assumes: host model drives scl, sda resolved with a pull-up
// Notes:   short write cycle parameter keeps polling quick
module cde_store_tb
  import cde_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TWR = 400;  // long enough that the first poll is refused
  logic sys_clk, sys_rst, card_present, slot_enable_low, scl, sda_low, sda_o, sda_oe, busy, if_enable;
  wire  sda;
  int   mismatches, n_compared;
  logic ok;
  logic [7:0] q[$];
  assign sda = ~(sda_low | (sda_oe & ~sda_o));  // open drain with pull-up
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
  cde_store #(.TWR_CYC(TWR)) cde_store_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .card_present(card_present),
    .slot_enable_low(slot_enable_low), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .busy(busy), .if_enable(if_enable));
  cde_host cde_host_i (.sys_clk(sys_clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // bus helpers
  function automatic logic [7:0] dev(input logic rd);
    return {card_present ? CDE_ADDR_PRESENT : CDE_ADDR_ABSENT, rd};
  endfunction : dev
  // at most one page per call
  task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
    logic k;
    cde_host_i.bus_start();
    cde_host_i.put_byte(dev(1'b0), ok);
    cde_host_i.put_byte(a[15:8], k);
    ok &= k;
    cde_host_i.put_byte(a[7:0], k);
    ok &= k;
    foreach (d[i]) begin
      cde_host_i.put_byte(d[i], k);
      ok &= k;
    end
    cde_host_i.bus_stop();
  endtask : wr
  task automatic rd(input logic [15:0] a, input int n);
    logic k;
    logic [7:0] b;
    q = {};
    cde_host_i.bus_start();
    cde_host_i.put_byte(dev(1'b0), k);
    cde_host_i.put_byte(a[15:8], k);
    cde_host_i.put_byte(a[7:0], k);
    cde_host_i.bus_start();
    cde_host_i.put_byte(dev(1'b1), k);
    for (int i = 0; i < n; i++) begin
      cde_host_i.get_byte(i == n - 1, b);
      q.push_back(b);
    end
    cde_host_i.bus_stop();
  endtask : rd
  // wait out the write cycle by address polling
  task automatic poll();
    logic k;
    for (int i = 0; i < 20; i++) begin
      cde_host_i.bus_start();
      cde_host_i.put_byte(dev(1'b0), k);
      cde_host_i.bus_stop();
      if (k === 1'b1) return;
    end
    mismatches++;
    tally_and_finish();
  endtask : poll
  // ==========================================================
  // scenarios
  task automatic t_address();
    logic k;
    for (int p = 0; p < 2; p++) begin
      card_present = p[0];
      cde_host_i.wt(4);
      cde_host_i.bus_start();
      cde_host_i.put_byte({CDE_ADDR_ABSENT, 1'b0}, k);
      cde_host_i.bus_stop();
      `CHK(k, p == 0)
      cde_host_i.bus_start();
      cde_host_i.put_byte({CDE_ADDR_PRESENT, 1'b0}, k);
      cde_host_i.bus_stop();
      `CHK(k, p == 1)
    end
    rd(16'h0010, 1);
    `CHK(q[0], CDE_MEM_RESET)
  endtask : t_address
  task automatic t_page_wrap();
    logic k;
    wr(16'h003e, '{8'h11, 8'h22, 8'h33});
    `CHK(ok, 1'b1)
    `CHK(busy, 1'b1)
    cde_host_i.bus_start();
    cde_host_i.put_byte(dev(1'b0), k);
    cde_host_i.bus_stop();
    `CHK(k, 1'b0)
    poll();
    wr(16'h001f, '{8'ha5, 8'h5a});
    poll();
    rd(16'h003e, 3);
    `CHK({q[0], q[1], q[2]}, {8'h11, 8'h22, CDE_BLANK})
    rd(16'h001f, 2);
    `CHK({q[0], q[1]}, 16'ha533)
    rd(16'h0000, 1);
    `CHK(q[0], 8'h5a)
  endtask : t_page_wrap
  task automatic t_out_of_range();
    slot_enable_low = 1'b1;
    cde_host_i.wt(4);
    `CHK(if_enable, 1'b0)
    wr(16'h0040, '{8'hc3});
    `CHK(ok, 1'b1)
    poll();
    rd(16'h0040, 2);
    `CHK({q[0], q[1]}, {CDE_BLANK, CDE_BLANK})
    rd(16'h0000, 1);
    `CHK(q[0], 8'h5a)
    slot_enable_low = 1'b0;
    cde_host_i.wt(4);
    `CHK(if_enable, 1'b1)
  endtask : t_out_of_range
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    card_present = 1'b0;
    slot_enable_low = 1'b0;
    mismatches = 0;
    n_compared = 0;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    cde_host_i.wt(2);
    t_address();
    t_page_wrap();
    t_out_of_range();
    tally_and_finish();
  end
endmodule : cde_store_tb
